/* File: design/hsi_flag_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hsi_flag_if #(parameter int N = 4);
    logic [N-1:0] set;
    logic clear;
    logic [N-1:0] flags;
    modport owner (input set, input clear, output flags);
    modport user (output set, output clear, input flags);
endinterface : hsi_flag_if
`default_nettype wire

/* File: design/hsi_pkg.sv */
package hsi_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h01;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'h02;
    localparam logic [7:0] ADDR_RX_PACKET_INFO = 8'h03;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Event status bit positions
    localparam int EV_CODE_CHANGE = 7;
    localparam int EV_FRAME_END = 6;
    localparam int EV_FRAME_START = 5;
    localparam int EV_RX_HALF_FULL = 4;
    localparam int EV_RX_HAS_DATA = 3;
    localparam int EV_TX_HALF_EMPTY = 2;
    localparam int EV_TX_HAS_ROOM = 1;
    localparam int EV_TX_DONE = 0;
    // Receive info bit positions
    localparam int RI_ABORT = 7;
    localparam int RI_CHECK_ERR = 6;
    localparam int RI_OVERFLOW = 5;
    localparam int RI_VALID = 4;
    localparam int RI_DRAINED = 3;
    localparam int RI_GOOD_LAST = 2;
    localparam int RI_CLOSING = 1;
    localparam int RI_OPENING = 0;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_CNT_W = 7;
    localparam int ABORT_ONES = 7;
endpackage : hsi_pkg

/* File: design/hsi_status_top.sv */
`timescale 1ns/1ps
`default_nettype none
module hsi_status_top
    import hsi_pkg::*;
(
    input wire logic clk_i,                     // 40 MHz clock
    input wire logic reset_i,                   // Sync reset, active high
    input wire logic [ADDR_W-1:0] addr_i,       // Register address
    input wire logic [DATA_W-1:0] wdata_i,      // Write data
    input wire logic wr_i,                      // Write strobe
    input wire logic rd_i,                      // Read strobe
    output logic [DATA_W-1:0] rdata_o,          // Read data, cycle after rd_i
    output logic irq_n_o,                       // Interrupt, active low
    input wire logic code_detected_i,           // Code detector sees valid code
    input wire logic rx_frame_start_i,          // Pulse: opening byte seen
    input wire logic rx_frame_ok_i,             // Pulse: frame done, check passed
    input wire logic rx_check_error_i,          // Pulse: checksum failed
    input wire logic rx_rx_bit_valid_i,         // Receive bit strobe
    input wire logic rx_bit_i,                  // Receive bit value
    input wire logic rx_fifo_write_i,           // Pulse: receiver writes a byte
    input wire logic [FIFO_CNT_W-1:0] rx_fifo_level_i, // Receive FIFO fill
    input wire logic rx_head_first_i,           // Head byte is first of frame
    input wire logic rx_head_last_i,            // Head byte is last of frame
    input wire logic rx_head_good_i,            // Head byte closes a good frame
    input wire logic [FIFO_CNT_W-1:0] tx_fifo_level_i, // Transmit FIFO fill
    input wire logic tx_frame_done_i            // Pulse: message sent
);
    logic [7:0] hdlc_event_mask;
    logic code_prev;
    logic [3:0] ones_run;
    logic rx_fifo_drained;
    logic rx_fifo_half_full;
    logic rx_fifo_has_data;
    logic tx_fifo_half_empty;
    logic tx_fifo_has_room;
    logic abort_pulse;
    logic overflow_pulse;
    logic rd_status;
    logic rd_info;
    logic [7:0] hdlc_event_status;
    logic [7:0] rx_packet_info;
    logic [7:0] next_rdata;
    logic next_irq_n;

    hsi_flag_if #(.N(4)) ev_if ();
    hsi_flag_if #(.N(4)) ri_if ();

    assign rd_status = rd_i && addr_i == ADDR_EVENT_STATUS;
    assign rd_info = rd_i && addr_i == ADDR_RX_PACKET_INFO;

    // Live FIFO level flags
    assign rx_fifo_drained = rx_fifo_level_i == '0;
    assign rx_fifo_has_data = !rx_fifo_drained;
    assign rx_fifo_half_full = rx_fifo_level_i > FIFO_CNT_W'(FIFO_DEPTH / 2);
    assign tx_fifo_half_empty = tx_fifo_level_i < FIFO_CNT_W'(FIFO_DEPTH / 2);
    assign tx_fifo_has_room = tx_fifo_level_i < FIFO_CNT_W'(FIFO_DEPTH);
    assign overflow_pulse = rx_fifo_write_i && rx_fifo_level_i == FIFO_CNT_W'(FIFO_DEPTH);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            code_prev <= 1'b0;
        else
            code_prev <= code_detected_i;
    end

    // Count consecutive ones; saturates so long idle runs do not wrap
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ones_run <= '0;
        else if (rx_rx_bit_valid_i)
            ones_run <= rx_bit_i ? (ones_run == 4'hf ? ones_run : ones_run + 4'h1) : 4'h0;
    end
    assign abort_pulse = rx_rx_bit_valid_i && rx_bit_i
        && ones_run == 4'(ABORT_ONES - 1);

    // Latched event bits: 3=code change, 2=frame end, 1=frame start, 0=tx done
    assign ev_if.set[3] = code_prev != code_detected_i;
    assign ev_if.set[2] = rx_frame_ok_i || rx_check_error_i
        || overflow_pulse || abort_pulse;
    assign ev_if.set[1] = rx_frame_start_i;
    assign ev_if.set[0] = tx_frame_done_i;
    assign ev_if.clear = rd_status;

    assign ri_if.set[3] = abort_pulse;
    assign ri_if.set[2] = rx_check_error_i;
    assign ri_if.set[1] = overflow_pulse;
    assign ri_if.set[0] = rx_frame_ok_i;
    assign ri_if.clear = rd_info;

    hsi_sticky #(.N(4)) u_ev (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .fl(ev_if.owner)
    );

    hsi_sticky #(.N(4)) u_ri (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .fl(ri_if.owner)
    );

    assign hdlc_event_status = {ev_if.flags[3:1], rx_fifo_half_full, rx_fifo_has_data,
        tx_fifo_half_empty, tx_fifo_has_room, ev_if.flags[0]};
    assign rx_packet_info = {ri_if.flags, rx_fifo_drained,
        rx_head_good_i && rx_head_last_i && !rx_fifo_drained,
        rx_head_last_i && !rx_fifo_drained,
        rx_head_first_i && !rx_fifo_drained};

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            hdlc_event_mask <= MASK_RESET;
        else if (wr_i && addr_i == ADDR_EVENT_MASK)
            hdlc_event_mask <= wdata_i;
    end

    always_comb
    begin
        next_rdata = '0;
        if (rd_i)
        begin
            unique case (addr_i)
                ADDR_EVENT_STATUS: next_rdata = hdlc_event_status;
                ADDR_EVENT_MASK: next_rdata = hdlc_event_mask;
                ADDR_RX_PACKET_INFO: next_rdata = rx_packet_info;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rdata_o <= '0;
        else
            rdata_o <= next_rdata;
    end

    // Latched bits drop on the read that clears them, so the pin follows
    assign next_irq_n = !(|(hdlc_event_status & hdlc_event_mask));

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_n_o <= 1'b1;
        else
            irq_n_o <= next_irq_n;
    end

    // The first edge after reset compares against the reset value of code_prev
    AST_CODE_CHANGE: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $changed(code_detected_i) && !$past(reset_i) |=> hdlc_event_status[EV_CODE_CHANGE])
        else $error("code change not flagged");

    AST_FRAME_END: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_check_error_i |=> hdlc_event_status[EV_FRAME_END] && rx_packet_info[RI_CHECK_ERR])
        else $error("frame end not flagged");

    AST_END_OK: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_frame_ok_i |=> hdlc_event_status[EV_FRAME_END])
        else $error("good frame end not flagged");

    AST_END_OVERFLOW: assert property (
        @(posedge clk_i) disable iff (reset_i)
        overflow_pulse |=> hdlc_event_status[EV_FRAME_END])
        else $error("overflow frame end not flagged");

    AST_END_ABORT: assert property (
        @(posedge clk_i) disable iff (reset_i)
        abort_pulse |=> hdlc_event_status[EV_FRAME_END])
        else $error("abort frame end not flagged");

    AST_FRAME_START: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_frame_start_i |=> hdlc_event_status[EV_FRAME_START])
        else $error("frame start not flagged");

    AST_HALF_FULL: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status |=> rdata_o[EV_RX_HALF_FULL] == $past(rx_fifo_half_full))
        else $error("half full bit wrong");

    AST_HALF_POINT: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_fifo_level_i == 7'h20 |-> !rx_fifo_half_full)
        else $error("half full set at half point");

    AST_HAS_DATA: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status |=> rdata_o[EV_RX_HAS_DATA] == $past(rx_fifo_has_data))
        else $error("has data bit wrong");

    AST_ONE_BYTE: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_fifo_level_i == 7'h01 |-> rx_fifo_has_data)
        else $error("single byte not reported");

    AST_HALF_EMPTY: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status |=> rdata_o[EV_TX_HALF_EMPTY] == $past(tx_fifo_half_empty))
        else $error("half empty bit wrong");

    AST_TX_HALF_POINT: assert property (
        @(posedge clk_i) disable iff (reset_i)
        tx_fifo_level_i == 7'h20 |-> !tx_fifo_half_empty)
        else $error("half empty set at half point");

    AST_HAS_ROOM: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status |=> rdata_o[EV_TX_HAS_ROOM] == $past(tx_fifo_has_room))
        else $error("has room bit wrong");

    AST_TX_FULL: assert property (
        @(posedge clk_i) disable iff (reset_i)
        tx_fifo_level_i == 7'h40 |-> !tx_fifo_has_room)
        else $error("room reported while full");

    AST_TX_DONE: assert property (
        @(posedge clk_i) disable iff (reset_i)
        tx_frame_done_i |=> hdlc_event_status[EV_TX_DONE])
        else $error("tx done not flagged");

    AST_READ_CLEARS: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status && !rx_frame_start_i |=> !hdlc_event_status[EV_FRAME_START])
        else $error("status read did not clear");

    AST_CODE_CLEARS: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status && !ev_if.set[3] |=> !hdlc_event_status[EV_CODE_CHANGE])
        else $error("code change not cleared");

    AST_DONE_CLEARS: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status && !tx_frame_done_i |=> !hdlc_event_status[EV_TX_DONE])
        else $error("tx done not cleared");

    AST_LATCH_HOLD: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !rd_status && hdlc_event_status[EV_FRAME_END] |=> hdlc_event_status[EV_FRAME_END])
        else $error("latched bit dropped without read");

    AST_MASKED: assert property (
        @(posedge clk_i) disable iff (reset_i)
        hdlc_event_mask == 8'h00 |=> irq_n_o)
        else $error("masked event raised interrupt");

    AST_MASK_WRITE: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_i && addr_i == ADDR_EVENT_MASK |=> hdlc_event_mask == $past(wdata_i))
        else $error("mask write lost");

    AST_READ_DATA: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_i && addr_i == ADDR_EVENT_MASK |=> rdata_o == $past(hdlc_event_mask))
        else $error("mask readback wrong");

    AST_RDATA_IDLE: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");

    AST_ABORT: assert property (
        @(posedge clk_i) disable iff (reset_i)
        abort_pulse |=> rx_packet_info[RI_ABORT])
        else $error("abort not flagged");

    AST_RUN_RESET: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_rx_bit_valid_i && !rx_bit_i |=> ones_run == 4'h0)
        else $error("ones run not restarted");

    AST_CHECK_ERR: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_check_error_i |=> rx_packet_info[RI_CHECK_ERR])
        else $error("check error not flagged");

    AST_OVERFLOW: assert property (
        @(posedge clk_i) disable iff (reset_i)
        overflow_pulse |=> rx_packet_info[RI_OVERFLOW])
        else $error("overflow not flagged");

    AST_VALID: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_frame_ok_i |=> rx_packet_info[RI_VALID])
        else $error("valid frame not flagged");

    AST_DRAINED: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_info |=> rdata_o[RI_DRAINED] == $past(rx_fifo_drained))
        else $error("empty bit wrong");

    AST_GOOD_LAST: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_packet_info[RI_GOOD_LAST] |-> rx_head_last_i && rx_head_good_i)
        else $error("good last tag without closing byte");

    AST_CLOSING: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_packet_info[RI_CLOSING] |-> rx_head_last_i && !rx_fifo_drained)
        else $error("closing tag wrong");

    AST_OPENING: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_packet_info[RI_OPENING] |-> rx_head_first_i && !rx_fifo_drained)
        else $error("opening tag wrong");

    AST_INFO_CLEAR: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_info && !rx_frame_ok_i |=> !rx_packet_info[RI_VALID])
        else $error("info read did not clear");

    AST_ABORT_CLEARS: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_info && !abort_pulse |=> !rx_packet_info[RI_ABORT])
        else $error("abort not cleared");

    AST_IRQ: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (hdlc_event_mask[EV_RX_HAS_DATA] && rx_fifo_has_data) |=> !irq_n_o)
        else $error("interrupt not asserted");

    // Pin is registered, so the release shows two edges after the read
    AST_IRQ_RELEASE: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status && hdlc_event_mask == 8'h20 && !rx_frame_start_i
        ##1 hdlc_event_mask == 8'h20 |=> irq_n_o)
        else $error("interrupt not released");

    AST_KEEP: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_status && rx_frame_start_i |=> hdlc_event_status[EV_FRAME_START])
        else $error("event lost during read");

    AST_KEEP_INFO: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_info && rx_frame_ok_i |=> rx_packet_info[RI_VALID])
        else $error("info event lost during read");
endmodule : hsi_status_top
`default_nettype wire

/* File: design/hsi_sticky.sv */
`timescale 1ns/1ps
`default_nettype none
module hsi_sticky #(
    parameter int N = 4
) (
    input wire logic clk_i,     // Clock
    input wire logic reset_i,   // Sync reset
    hsi_flag_if.owner fl        // Set, clear-on-read and flags
);
    // Set wins over the clear so an event during the read is kept
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            fl.flags <= '0;
        else if (fl.clear)
            fl.flags <= fl.set;
        else
            fl.flags <= fl.flags | fl.set;
    end

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (reset_i)
        fl.set[0] |=> fl.flags[0]) else $error("set event lost");
    AST_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
        fl.clear && !fl.set[0] |=> !fl.flags[0]) else $error("flag not cleared");
endmodule : hsi_sticky
`default_nettype wire

/* File: verif/tb_hsi_status_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_hsi_status_top;
    import hsi_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_n_o;
    logic code_i = 1'b0;
    logic [4:0] ev = 5'h00; // tx done, fifo write, check error, frame ok, frame start
    logic bv = 1'b0;
    logic bit_i = 1'b0;
    logic [6:0] rx_lvl = 7'h00;
    logic [6:0] tx_lvl = 7'h40;
    logic [2:0] head = 3'h0; // good, last, first
    logic [7:0] got;
    int n_errors = 0;
    int checks_done = 0;
    hsi_status_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_n_o(irq_n_o), .code_detected_i(code_i),
        .rx_frame_start_i(ev[0]), .rx_frame_ok_i(ev[1]), .rx_check_error_i(ev[2]),
        .rx_rx_bit_valid_i(bv), .rx_bit_i(bit_i), .rx_fifo_write_i(ev[3]),
        .rx_fifo_level_i(rx_lvl), .rx_head_first_i(head[0]), .rx_head_last_i(head[1]),
        .rx_head_good_i(head[2]), .tx_fifo_level_i(tx_lvl), .tx_frame_done_i(ev[4]));
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
    endtask : rd
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task pulse(input logic [4:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 5'h00;
    endtask : pulse
    task cyc_irq(input int n, input logic [7:0] exp);
        repeat (n) @(posedge clk_i);
        #1 chk("irq", exp, {7'h00, irq_n_o});
    endtask : cyc_irq
    task t_regs;
        rd(ADDR_EVENT_MASK); chk("mask", MASK_RESET, got);
        @(posedge clk_i);
        #1 chk("rdata idle", 8'h00, rdata_o);
        rd(8'h00); chk("unmapped", 8'h00, got);
        wr(ADDR_EVENT_STATUS, 8'hff);
        rd(ADDR_EVENT_STATUS); chk("status", 8'h00, got);
        rd(ADDR_RX_PACKET_INFO); chk("info", 8'h08, got);
        wr(ADDR_EVENT_MASK, 8'ha5);
        rd(ADDR_EVENT_MASK); chk("mask", 8'ha5, got);
        wr(ADDR_EVENT_MASK, 8'h00);
    endtask : t_regs
    task t_levels;
        logic [6:0] rl [5] = '{7'h00, 7'h01, 7'h20, 7'h21, 7'h40};
        logic [6:0] tl [5] = '{7'h40, 7'h3f, 7'h20, 7'h1f, 7'h00};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_i);
            rx_lvl <= rl[i];
            tx_lvl <= tl[i];
            rd(ADDR_EVENT_STATUS);
            chk("levels", {3'h0, rl[i] > 32, rl[i] > 0, tl[i] < 32, tl[i] < 64, 1'b0}, got);
            rd(ADDR_RX_PACKET_INFO); chk("empty", {4'h0, rl[i] == 0, 3'h0}, got);
        end
        @(posedge clk_i);
        rx_lvl <= 7'h00;
        tx_lvl <= 7'h40;
    endtask : t_levels
    task t_events;
        logic [4:0] em [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
        logic [7:0] es [4] = '{8'h20, 8'h40, 8'h40, 8'h01};
        logic [7:0] ei [4] = '{8'h08, 8'h18, 8'h48, 8'h08};
        for (int i = 0; i < 4; i++)
        begin
            pulse(em[i]);
            rd(ADDR_EVENT_STATUS); chk("ev status", es[i], got);
            rd(ADDR_RX_PACKET_INFO); chk("ev info", ei[i], got);
            rd(ADDR_EVENT_STATUS); chk("ev clear", 8'h00, got);
            rd(ADDR_RX_PACKET_INFO); chk("ev info clear", 8'h08, got);
        end
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_i);
            code_i <= ~code_i;
            @(posedge clk_i);
            rd(ADDR_EVENT_STATUS); chk("code change", 8'h80, got);
            rd(ADDR_EVENT_STATUS); chk("code clear", 8'h00, got);
        end
    endtask : t_events
    task t_rx_faults;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_i);
            rx_lvl <= 7'h3f + 7'(i);
            pulse(5'h08);
            rd(ADDR_RX_PACKET_INFO); chk("overflow", {2'h0, i == 1, 5'h00}, got);
        end
        rd(ADDR_RX_PACKET_INFO); chk("overflow clear", 8'h00, got);
        for (int n = 6; n < 8; n++)
        begin
            for (int b = 0; b <= n; b++)
            begin
                @(posedge clk_i);
                bv <= 1'b1;
                bit_i <= (b < n);
            end
            @(posedge clk_i);
            bv <= 1'b0;
            rd(ADDR_RX_PACKET_INFO); chk("abort", {n == 7, 7'h00}, got);
        end
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk_i);
            head <= 3'(k);
            rd(ADDR_RX_PACKET_INFO);
            chk("tags", {5'h00, k[2] && k[1], k[1], k[0]}, got);
        end
        @(posedge clk_i);
        rx_lvl <= 7'h00;
        rd(ADDR_RX_PACKET_INFO); chk("tags empty", 8'h08, got);
        @(posedge clk_i);
        head <= 3'h0;
        // Overflow and abort also ended a frame; clear it before the next scenario
        rd(ADDR_EVENT_STATUS); chk("fault end", 8'h40, got);
    endtask : t_rx_faults
    task t_irq;
        wr(ADDR_EVENT_MASK, 8'h20);
        pulse(5'h01);
        cyc_irq(1, 8'h00);
        rd(ADDR_EVENT_STATUS); chk("irq cause", 8'h20, got);
        cyc_irq(1, 8'h01);
        wr(ADDR_EVENT_MASK, 8'hdf);
        pulse(5'h01);
        cyc_irq(2, 8'h01);
        rd(ADDR_EVENT_STATUS);
        wr(ADDR_EVENT_MASK, 8'h02);
        tx_lvl <= 7'h3f;
        cyc_irq(2, 8'h00);
        @(posedge clk_i);
        tx_lvl <= 7'h40;
        cyc_irq(2, 8'h01);
        wr(ADDR_EVENT_MASK, 8'h00);
        // Event arrives in the very cycle that the clearing read is taken
        @(posedge clk_i);
        addr_i <= ADDR_EVENT_STATUS;
        rd_i <= 1'b1;
        ev <= 5'h01;
        @(posedge clk_i);
        rd_i <= 1'b0;
        ev <= 5'h00;
        rd(ADDR_EVENT_STATUS); chk("kept", 8'h20, got);
    endtask : t_irq
    task print_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_levels();
        t_events();
        t_rx_faults();
        t_irq();
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end
endmodule : tb_hsi_status_top
`default_nettype wire
